// ==== rtl/scs_map.vh ====
`ifndef SCS_MAP_VH
`define SCS_MAP_VH
`define SCS_CH_W          3
`define SCS_CH_LAST       3'h4
`define SCS_CH_ZERO       3'h0
`define SCS_POLE_W        5
`define SCS_DWELL_W       7
`define SCS_DWELL_MAX     7'h63
`define SCS_SEC_NS        1000000000
`define SCS_CLK_NS        25
`define SCS_SEC_CYCLES    (`SCS_SEC_NS / `SCS_CLK_NS)
`define SCS_SETTLE_NS     5000000
`define SCS_SETTLE_CYCLES (`SCS_SETTLE_NS / `SCS_CLK_NS)
`define SCS_CNT_W         26
`define SCS_ID_SW4        3
`endif

// ==== rtl/scs_sync.v ====
`timescale 1ns/100ps
// Two-stage synchroniser for a bus of asynchronous levels.
module scs_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end
   assign dout = sync_ff;
endmodule // scs_sync

// ==== rtl/scs_sequencer.v ====
`timescale 1ns/100ps
`include "scs_map.vh"
// What this block does
// - Outside a switch, exactly one of channels 0..4 reaches the shared input card.
// - Each step key press advances 0,1,2,3,4 then back to 0.
// - Each added channel may be selected directly or included in the scan.
// - Each added channel has its own dwell of 0..99 seconds during scanning.
// - Current poles make before break; voltage poles break before make.
// - Three-bit binary channel code, 000..100 for channels 0..4.
// - Code bits drive high for one and low for zero.
// - Remote commands act exactly as the local key and dwell actions.
// - Channels 0..4 map to remote curve slots 0..4.
// - Units of the shared card apply to all added channels.
// - One per-card resolution applies to all scanner channels.
// - Curve slot always follows channel; it is flagged valid only while identity switch 4 is open.
module scs_sequencer #(
   parameter SEC_CYCLES    = `SCS_SEC_CYCLES,
   parameter SETTLE_CYCLES = `SCS_SETTLE_CYCLES
) (
   input  wire        ref_clk,
   input  wire        nrst,
   input  wire        step_key_n,
   input  wire        remote_step,
   input  wire        remote_select,
   input  wire [2:0]  remote_channel,
   input  wire        remote_dwell_wr,
   input  wire [2:0]  remote_dwell_channel,
   input  wire [6:0]  remote_dwell_value,
   input  wire        scan_enable,
   input  wire [4:0]  scan_include,
   input  wire [3:0]  id_switch,
   input  wire [1:0]  card_units,
   input  wire [1:0]  card_resolution,
   output reg  [4:0]  current_pole_ff,
   output reg  [4:0]  voltage_pole_ff,
   output reg         channel_code_bit0,
   output reg         channel_code_bit1,
   output reg         channel_code_bit2,
   output reg  [2:0]  curve_slot_ff,
   output reg         curve_slot_valid_ff,
   output reg  [1:0]  units_ff,
   output reg  [1:0]  resolution_ff,
   output reg         busy_ff
);
   localparam ST_IDLE   = 3'h0;
   localparam ST_MAKE_I = 3'h1;
   localparam ST_BRK_I  = 3'h2;
   localparam ST_BRK_V  = 3'h3;
   localparam ST_MAKE_V = 3'h4;
   localparam [31:0]           SEC_LAST_W = SEC_CYCLES - 1;
   localparam [31:0]           SET_LAST_W = SETTLE_CYCLES - 1;
   localparam [`SCS_CNT_W-1:0] SEC_LAST   = SEC_LAST_W[`SCS_CNT_W-1:0];
   localparam [`SCS_CNT_W-1:0] SET_LAST   = SET_LAST_W[`SCS_CNT_W-1:0];

   reg        rst_meta_ff;
   reg        rst_n_ff;
   wire       rst_n = rst_n_ff;
   wire [4:0] pin_s;
   wire       key_s = pin_s[0];
   wire [3:0] id_s  = pin_s[4:1];
   reg        key_prev_ff;
   reg  [2:0] st_ff;
   reg  [2:0] nxt_st;
   reg  [2:0] chan_ff;
   reg  [2:0] tgt_ff;
   reg  [2:0] nxt_tgt;
   reg        nxt_go;
   reg  [`SCS_CNT_W-1:0] settle_ff;
   reg  [`SCS_CNT_W-1:0] sec_ff;
   reg  [6:0] dwell_left_ff;
   reg  [6:0] dwell_ff [0:4];
   wire       key_press = key_s & ~key_prev_ff;
   wire       settled = (settle_ff == SET_LAST);
   wire       sec_tick = (sec_ff == SEC_LAST);
   // A dwell of zero leaves at once; otherwise the stay ends with its last whole second.
   wire       dwell_done = (dwell_left_ff == 7'h00) ||
                           (sec_tick && dwell_left_ff == 7'h01);
   wire [4:0] tgt_hot = 5'h01 << tgt_ff;
   wire [4:0] cur_hot = 5'h01 << chan_ff;
   integer    k;

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // The key enters inverted, so a pressed key reads one and the synchroniser's
   // cleared state matches the idle key: no false press follows reset.
   scs_sync #(.W(5)) u_pin_sync (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .din   ({id_switch, ~step_key_n}),
      .dout  (pin_s)
   );

   function [2:0] next_ch;
      input [2:0] c;
      begin
         if (c == `SCS_CH_LAST)
            next_ch = `SCS_CH_ZERO;
         else
            next_ch = c + 3'h1;
      end
   endfunction

   // Next channel of the scan: first included channel after the current one.
   function [2:0] next_scan;
      input [2:0] c;
      input [4:0] inc;
      reg   [2:0] p;
      integer     i;
      begin
         p = c;
         next_scan = c;
         for (i = 0; i < 5; i = i + 1) begin
            p = next_ch(p);
            if (inc[p] && next_scan == c)
               next_scan = p;
         end
      end
   endfunction

   // Request arbitration; remote requests are the same actions as the key.
   always @* begin
      nxt_go  = 1'b0;
      nxt_tgt = chan_ff;
      if (remote_select && remote_channel <= `SCS_CH_LAST) begin
         nxt_go  = 1'b1;
         nxt_tgt = remote_channel;
      end else if (key_press || remote_step) begin
         nxt_go  = 1'b1;
         nxt_tgt = next_ch(chan_ff);
      end else if (scan_enable && dwell_done) begin
         nxt_go  = 1'b1;
         nxt_tgt = next_scan(chan_ff, scan_include | 5'h01);
      end
   end

   // Make-before-break on current poles, break-before-make on voltage poles.
   always @* begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE:   if (nxt_go && nxt_tgt != chan_ff) nxt_st = ST_MAKE_I;
         ST_MAKE_I: if (settled) nxt_st = ST_BRK_I;
         ST_BRK_I:  if (settled) nxt_st = ST_BRK_V;
         ST_BRK_V:  if (settled) nxt_st = ST_MAKE_V;
         ST_MAKE_V: if (settled) nxt_st = ST_IDLE;
         default:   nxt_st = ST_IDLE;
      endcase
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         key_prev_ff   <= 1'b0;
         st_ff         <= ST_IDLE;
         chan_ff       <= `SCS_CH_ZERO;
         tgt_ff        <= `SCS_CH_ZERO;
         settle_ff     <= {`SCS_CNT_W{1'b0}};
         sec_ff        <= {`SCS_CNT_W{1'b0}};
         dwell_left_ff <= 7'h00;
         current_pole_ff <= 5'h01;
         voltage_pole_ff <= 5'h01;
         channel_code_bit0 <= 1'b0;
         channel_code_bit1 <= 1'b0;
         channel_code_bit2 <= 1'b0;
         curve_slot_ff <= `SCS_CH_ZERO;
         curve_slot_valid_ff <= 1'b0;
         units_ff      <= 2'h0;
         resolution_ff <= 2'h0;
         busy_ff       <= 1'b0;
         for (k = 0; k < 5; k = k + 1)
            dwell_ff[k] <= 7'h00;
      end else begin
         key_prev_ff <= key_s;
         st_ff       <= nxt_st;
         busy_ff     <= (nxt_st != ST_IDLE);
         units_ff      <= card_units;
         resolution_ff <= card_resolution;
         if (remote_dwell_wr && remote_dwell_channel <= `SCS_CH_LAST &&
             remote_dwell_value <= `SCS_DWELL_MAX)
            dwell_ff[remote_dwell_channel] <= remote_dwell_value;
         if (st_ff == ST_IDLE || settled)
            settle_ff <= {`SCS_CNT_W{1'b0}};
         else
            settle_ff <= settle_ff + 1'b1;
         if (st_ff != ST_IDLE || !scan_enable || sec_ff == SEC_LAST)
            sec_ff <= {`SCS_CNT_W{1'b0}};
         else
            sec_ff <= sec_ff + 1'b1;
         // Dwell is reloaded on arrival and counted down once per second while idle.
         if (st_ff == ST_MAKE_V && settled)
            dwell_left_ff <= dwell_ff[tgt_ff];
         else if (st_ff == ST_IDLE && sec_tick && dwell_left_ff > 7'h01)
            dwell_left_ff <= dwell_left_ff - 7'h01;
         case (st_ff)
            ST_IDLE: if (nxt_st == ST_MAKE_I) begin
               tgt_ff <= nxt_tgt;
               current_pole_ff <= cur_hot | (5'h01 << nxt_tgt);
            end
            ST_MAKE_I: if (settled) current_pole_ff <= tgt_hot;
            ST_BRK_I:  if (settled) voltage_pole_ff <= 5'h00;
            ST_BRK_V:  if (settled) voltage_pole_ff <= tgt_hot;
            ST_MAKE_V: if (settled) begin
               chan_ff <= tgt_ff;
               channel_code_bit0 <= tgt_ff[0];
               channel_code_bit1 <= tgt_ff[1];
               channel_code_bit2 <= tgt_ff[2];
               // The slot moves on the same edge as the code so the two never disagree.
               curve_slot_ff <= tgt_ff;
            end
            default: ;
         endcase
         curve_slot_valid_ff <= ~id_s[`SCS_ID_SW4];
      end
   end
endmodule // scs_sequencer

// ==== verification/scs_monitor.sv ====
`timescale 1ns/100ps
module scs_monitor #(
   parameter int SETTLE_CYCLES = 4
) (
   input wire logic       ref_clk,
   input wire logic       nrst,
   input wire logic [4:0] current_pole_ff,
   input wire logic [4:0] voltage_pole_ff,
   input wire logic       channel_code_bit0,
   input wire logic       channel_code_bit1,
   input wire logic       channel_code_bit2,
   input wire logic [2:0] curve_slot_ff,
   input wire logic       curve_slot_valid_ff,
   input wire logic       busy_ff
);
   localparam int S1 = SETTLE_CYCLES;
   localparam int S2 = 2 * SETTLE_CYCLES;
   localparam int S4 = 4 * SETTLE_CYCLES - 1;
   wire [2:0] code = {channel_code_bit2, channel_code_bit1, channel_code_bit0};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_start;
      $rose(busy_ff);
   endsequence
   a_one_route: assert property (!busy_ff |-> $onehot(voltage_pole_ff))
      else $error("voltage poles not one-hot");
   a_code_range: assert property (code <= 3'h4)
      else $error("code out of range");
   a_code_poles: assert property (!busy_ff |-> voltage_pole_ff == (5'h01 << code))
      else $error("code disagrees with poles");
   a_current_make: assert property (s_start |-> $countones(current_pole_ff) == 2
      ##S1 $countones(current_pole_ff) == 1) else $error("current poles not make first");
   a_voltage_break: assert property (s_start |-> ##S2 voltage_pole_ff == 5'h00)
      else $error("voltage poles not break first");
   a_busy_span: assert property (s_start |-> ##S4 busy_ff ##1 !busy_ff)
      else $error("switch length wrong");
   a_code_late: assert property (busy_ff |-> $stable(code))
      else $error("code moved while switching");
   a_slot_follows: assert property (!busy_ff && curve_slot_valid_ff |-> curve_slot_ff == code)
      else $error("curve slot differs from channel");
endmodule // scs_monitor

bind scs_sequencer scs_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (
   .ref_clk             (ref_clk),
   .nrst                (nrst),
   .current_pole_ff     (current_pole_ff),
   .voltage_pole_ff     (voltage_pole_ff),
   .channel_code_bit0   (channel_code_bit0),
   .channel_code_bit1   (channel_code_bit1),
   .channel_code_bit2   (channel_code_bit2),
   .curve_slot_ff       (curve_slot_ff),
   .curve_slot_valid_ff (curve_slot_valid_ff),
   .busy_ff             (busy_ff)
);

// ==== verification/scs_key_model.sv ====
`timescale 1ns/100ps
// Front key: a press request holds the contact closed for eight clocks.
module scs_key_model (
   input  wire logic ref_clk,
   input  wire logic press,
   output logic      step_key_n
);
   int hold = 0;
   assign step_key_n = (hold == 0);
   always @(posedge ref_clk) begin
      if (press) hold <= 8;
      else if (hold != 0) hold <= hold - 1;
   end
endmodule // scs_key_model

// ==== verification/scs_sequencer_test.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
module scs_sequencer_test;
   logic       ref_clk = 1'b0, nrst = 1'b0, press = 1'b0, step_key_n, busy_ff;
   logic       remote_step = 1'b0, remote_select = 1'b0, remote_dwell_wr = 1'b0;
   logic       scan_enable = 1'b0, curve_slot_valid_ff;
   logic       channel_code_bit0, channel_code_bit1, channel_code_bit2;
   logic [2:0] remote_channel = 3'h0, remote_dwell_channel = 3'h0, curve_slot_ff;
   logic [6:0] remote_dwell_value = 7'h01;
   logic [4:0] scan_include = 5'h05, current_pole_ff, voltage_pole_ff;
   logic [3:0] id_switch = 4'h0;
   logic [1:0] card_units = 2'h2, card_resolution = 2'h1, units_ff, resolution_ff;
   int         fails = 0, tests_run = 0;
   wire  [2:0] code = {channel_code_bit2, channel_code_bit1, channel_code_bit0};
   localparam int SETTLE = 4;
   localparam int SEC    = 20;
   scs_sequencer #(.SEC_CYCLES(SEC), .SETTLE_CYCLES(SETTLE)) u_dut (
      .ref_clk              (ref_clk),
      .nrst                 (nrst),
      .step_key_n           (step_key_n),
      .remote_step          (remote_step),
      .remote_select        (remote_select),
      .remote_channel       (remote_channel),
      .remote_dwell_wr      (remote_dwell_wr),
      .remote_dwell_channel (remote_dwell_channel),
      .remote_dwell_value   (remote_dwell_value),
      .scan_enable          (scan_enable),
      .scan_include         (scan_include),
      .id_switch            (id_switch),
      .card_units           (card_units),
      .card_resolution      (card_resolution),
      .current_pole_ff      (current_pole_ff),
      .voltage_pole_ff      (voltage_pole_ff),
      .channel_code_bit0    (channel_code_bit0),
      .channel_code_bit1    (channel_code_bit1),
      .channel_code_bit2    (channel_code_bit2),
      .curve_slot_ff        (curve_slot_ff),
      .curve_slot_valid_ff  (curve_slot_valid_ff),
      .units_ff             (units_ff),
      .resolution_ff        (resolution_ff),
      .busy_ff              (busy_ff)
   );
   scs_key_model u_key (.ref_clk(ref_clk), .press(press), .step_key_n(step_key_n));
   always #12.5 ref_clk = ~ref_clk;
   task automatic settle(input logic [2:0] exp);
      int n;
      n = 0;
      while (busy_ff !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      `CHK("start", 1'b1, busy_ff)
      n = 0;
      while (busy_ff !== 1'b0 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      `CHK("span", 4 * SETTLE, n)
      `CHK("code", exp, code)
      `CHK("poles", 5'h01 << exp, voltage_pole_ff)
   endtask
   task automatic no_switch(input logic [2:0] exp);
      logic seen;
      seen = 1'b0;
      repeat (8) begin
         @(negedge ref_clk);
         seen = seen | busy_ff;
      end
      `CHK("refused", 1'b0, seen)
      `CHK("code", exp, code)
   endtask
   task automatic t_key();
      for (int i = 1; i <= 5; i++) begin
         press = 1'b1;
         @(negedge ref_clk);
         press = 1'b0;
         settle(3'(i % 5));
      end
   endtask
   task automatic t_remote();
      remote_step = 1'b1;
      @(negedge ref_clk);
      remote_step = 1'b0;
      settle(3'h1);
      for (int i = 0; i < 3; i++) begin
         remote_channel = (i == 1) ? 3'h7 : 3'h4;
         remote_select = 1'b1;
         @(negedge ref_clk);
         remote_select = 1'b0;
         if (i == 0) begin
            settle(3'h4);
         end else begin
            no_switch(3'h4);
         end
      end
   endtask
   task automatic wait_code(input logic [2:0] exp);
      int n;
      n = 0;
      while ((code !== exp || busy_ff !== 1'b0) && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      `CHK("scan", exp, code)
   endtask
   task automatic t_scan();
      int n;
      for (int i = 0; i < 5; i++) begin
         remote_dwell_channel = 3'(i);
         remote_dwell_wr = 1'b1;
         @(negedge ref_clk);
         remote_dwell_wr = 1'b0;
         @(negedge ref_clk);
      end
      scan_enable = 1'b1;
      wait_code(3'h0);
      n = 0;
      while (busy_ff !== 1'b1 && n < 2 * SEC) begin
         @(negedge ref_clk);
         n++;
      end
      `CHK("dwell", SEC, n)
      wait_code(3'h2);
      scan_enable = 1'b0;
   endtask
   task automatic t_ident();
      `CHK("slot", 3'h2, curve_slot_ff)
      `CHK("valid", 1'b1, curve_slot_valid_ff)
      `CHK("units", card_units, units_ff)
      `CHK("res", card_resolution, resolution_ff)
      id_switch = 4'h8;
      card_units = 2'h1;
      repeat (8) @(negedge ref_clk);
      `CHK("valid", 1'b0, curve_slot_valid_ff)
      `CHK("units", 2'h1, units_ff)
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (8) @(negedge ref_clk);
      `CHK("reset", 5'h01, voltage_pole_ff)
      t_key();
      t_remote();
      t_scan();
      t_ident();
      end_sim();
   end
   initial begin
      #200000;
      fails++;
      end_sim();
   end
endmodule // scs_sequencer_test
